/* fsp_pkg.sv */
// What this block does
// - Status write ones in bits 5-2 protects all
// - Status write zeros in bits 5-2 unprotects all
// - Mixed bits 5-2 leave protection unchanged
// - Lock clear: bit 7 loads lock bit
// - 00h unprotects, 7Fh protects, lock stays
// - Pin low and locked: writes ignored
// - Pin high and locked: only lock clears
// - 0Fh clears lock when pin deasserted
// - F0h sets lock, sectors unchanged
// - Bits 5-2 decoded, only bit 7 stored
// - Status read shows pin and protection state
// - Single sector commands work after global
// - Output repeats FFh protected, 00h not
// - Chip select high ends read, floats output
// - Protection read omits write-protect pin
// - Summary field: all, some or none
// - Status write needs write enable latch
// - Reset protects every sector
// - Hardware lock needs pin and lock bit
package fsp_pkg;
	// Array geometry
	localparam int NUM_SECTORS = 4;
	localparam int SEC_W = 2;
	localparam int ADDR_BYTES = 3;
	// Command opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_PROT = 8'h36;
	localparam logic [7:0] OP_UNPROT = 8'h39;
	localparam logic [7:0] OP_RDSP = 8'h3C;
	// Status byte field positions
	localparam int ST_LOCK = 7;
	localparam int GLOB_HI = 5;
	localparam int GLOB_LO = 2;
	localparam int ST_WPIN = 4;
	localparam int ST_SUM_LO = 2;
	localparam int ST_WEL = 1;
	// Summary encodings
	localparam logic [1:0] SUM_NONE = 2'h0;
	localparam logic [1:0] SUM_SOME = 2'h1;
	localparam logic [1:0] SUM_ALL = 2'h3;
	// Protection read bytes
	localparam logic [7:0] RD_PROT = 8'hFF;
	localparam logic [7:0] RD_UNPROT = 8'h00;
	// Reset values
	localparam logic [NUM_SECTORS-1:0] SECTOR_RST = 4'hF;
	localparam logic LOCK_RST = 1'b0;
	localparam logic WEL_RST = 1'b0;
	// Command sequencer states, Gray in the order listed
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_OPCODE = 3'h1,
		ST_ADDR = 3'h3,
		ST_DATA = 3'h2,
		ST_OUT = 3'h6,
		ST_SKIP = 3'h7
	} fsp_state_type;
endpackage : fsp_pkg

/* fsp_sync.sv */
`timescale 1ns/1ps
module fsp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Asynchronous levels in, synchronised out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	// One two-stage chain per bit; first stage read only by second
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic meta_reg;
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					meta_reg <= RST_VAL[g];
					sync_o[g] <= RST_VAL[g];
				end else begin
					meta_reg <= async_i[g];
					sync_o[g] <= meta_reg;
				end
			end
		end
	endgenerate
endmodule : fsp_sync

/* fsp_glob_decode.sv */
`timescale 1ns/1ps
module fsp_glob_decode
	import fsp_pkg::*;
(
	// Current lock state and pin
	input wire logic lock_i,
	input wire logic wp_n_i,
	// Written status byte
	input wire logic [7:0] data_i,
	// Decoded outcome
	output logic lock_next_o,
	output logic glob_set_o,
	output logic glob_clr_o
);
	// Hard lock freezes everything
	wire hard_lock = ~wp_n_i & lock_i;
	// Only bits 5..2 and bit 7 matter
	wire [3:0] glob_field = data_i[GLOB_HI:GLOB_LO];
	// Globals only while unlocked; soft lock just lets bit 7 through
	assign lock_next_o = hard_lock ? lock_i : data_i[ST_LOCK];
	assign glob_set_o = ~lock_i & (&glob_field);
	assign glob_clr_o = ~lock_i & ~(|glob_field);
endmodule : fsp_glob_decode

/* fsp_ctrl.sv */
`timescale 1ns/1ps
module fsp_ctrl
	import fsp_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Serial link pins
	input wire logic spi_sck_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_si_i,
	output logic spi_so_o,
	output logic spi_so_oe_o,
	// Write-protect pin, low asserts
	input wire logic wp_n_i,
	// Protection state
	output logic [NUM_SECTORS-1:0] sector_protect_o,
	output logic protection_lock_bit_o,
	output logic write_enable_latch_o,
	output logic [1:0] software_protect_summary_o,
	output logic hard_locked_o,
	output logic [7:0] status_o
);

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	// Commands that carry three address bytes
	function automatic logic needs_addr(input logic [7:0] op);
		needs_addr = (op == OP_PROT) || (op == OP_UNPROT) || (op == OP_RDSP);
	endfunction : needs_addr

	// Commands that change one sector bit
	function automatic logic is_sector_cmd(input logic [7:0] op);
		is_sector_cmd = (op == OP_PROT) || (op == OP_UNPROT);
	endfunction : is_sector_cmd

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Synchronised copies of all pin inputs
	logic sck_s;
	logic cs_n_s;
	logic si_s;
	logic wp_n_s;

	// Chains reset to the idle levels: clock low, select high, data low, pin high
	fsp_sync #(
		.W(4),
		.RST_VAL(4'h5)
	) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.async_i({spi_sck_i, spi_cs_n_i, spi_si_i, wp_n_i}),
		.sync_o({sck_s, cs_n_s, si_s, wp_n_s})
	);

	////////////////////////////////////////////////////////////////////////
	// Registers

	// Delayed copies for edge finding
	logic sck_d_reg;
	logic cs_n_d_reg;
	// Command sequencer
	fsp_state_type state_reg;
	fsp_state_type state_next;
	// Bit within byte, and address byte count
	logic [2:0] bit_cnt_reg;
	logic [1:0] addr_cnt_reg;
	// Input shifter and captured bytes
	logic [7:0] shift_reg;
	logic [7:0] op_reg;
	logic [7:0] data_reg;
	logic [SEC_W-1:0] sec_sel_reg;
	// Completion flags for the command in flight
	logic got_data_reg;
	logic addr_done_reg;
	// Output shifter and pin registers
	logic [7:0] out_shift_reg;
	logic so_reg;
	logic so_oe_reg;
	// Protection state proper
	logic [NUM_SECTORS-1:0] sector_reg;
	logic [NUM_SECTORS-1:0] sector_next;
	logic lock_reg;
	logic lock_next;
	logic wel_reg;
	logic wel_next;
	logic [1:0] summary_reg;
	logic hard_lock_reg;

	////////////////////////////////////////////////////////////////////////
	// Link event decode

	// SCK sampled at 10 MHz; mode 0, so data in on rise, out on fall
	wire sck_rise = sck_s & ~sck_d_reg;
	wire sck_fall = ~sck_s & sck_d_reg;
	// Chip select release ends any command
	wire cs_end = cs_n_s & ~cs_n_d_reg;
	wire active = ~cs_n_s;
	// Next shifter value and byte completion
	wire [7:0] shift_in = {shift_reg[6:0], si_s};
	wire byte_done = sck_rise & (bit_cnt_reg == 3'h7);
	wire last_addr = addr_cnt_reg == 2'(ADDR_BYTES - 1);
	// Release off a byte boundary aborts execution
	wire on_boundary = bit_cnt_reg == 3'h0;
	wire exec_ok = cs_end & on_boundary & (state_reg != ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Status and protection read data

	// Bits 4..2 report pin and summary, bit 5 reads zero; never written values
	wire [7:0] status_byte = {
		lock_reg, 2'h0, wp_n_s, summary_reg, wel_reg, 1'b0};
	// Only the sector bit; pin state is not part of it
	wire sec_bit = sector_reg[sec_sel_reg];
	wire [7:0] rdsp_byte = sec_bit ? RD_PROT : RD_UNPROT;

	////////////////////////////////////////////////////////////////////////
	// Command sequencer

	// Walks opcode, address and data; output phase loops until release
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (active) begin
					state_next = ST_OPCODE;
				end
			end
			ST_OPCODE: begin
				if (byte_done) begin
					if (shift_in == OP_RDSR) begin
						state_next = ST_OUT;
					end else if (needs_addr(shift_in)) begin
						state_next = ST_ADDR;
					end else if (shift_in == OP_WRSR) begin
						state_next = ST_DATA;
					end else begin
						// Trailing data of other opcodes is dropped
						state_next = ST_SKIP;
					end
				end
			end
			ST_ADDR: begin
				if (byte_done && last_addr) begin
					state_next = (op_reg == OP_RDSP) ? ST_OUT : ST_SKIP;
				end
			end
			ST_DATA: begin
				if (byte_done) begin
					state_next = ST_SKIP;
				end
			end
			ST_OUT: begin
				state_next = ST_OUT;
			end
			ST_SKIP: begin
				state_next = ST_SKIP;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// Release wins over everything
		if (cs_n_s) begin
			state_next = ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Execution decode

	// Global decode of the written byte
	logic wsr_lock_next;
	logic glob_set;
	logic glob_clr;

	fsp_glob_decode u_glob (
		.lock_i(lock_reg),
		.wp_n_i(wp_n_s),
		.data_i(data_reg),
		.lock_next_o(wsr_lock_next),
		.glob_set_o(glob_set),
		.glob_clr_o(glob_clr)
	);

	// Status write runs only with the latch set
	wire wsr_fire = exec_ok & (op_reg == OP_WRSR) & got_data_reg & wel_reg;
	// Sector commands need full address and no lock
	wire sec_fire = exec_ok & is_sector_cmd(op_reg) & addr_done_reg & wel_reg & ~lock_reg;
	wire [NUM_SECTORS-1:0] sec_onehot = NUM_SECTORS'(1) << sec_sel_reg;

	// Global and lock land on the same edge
	assign lock_next = wsr_fire ? wsr_lock_next : lock_reg;
	always_comb begin
		sector_next = sector_reg;
		if (wsr_fire && glob_set) begin
			sector_next = '1;
		end else if (wsr_fire && glob_clr) begin
			sector_next = '0;
		end else if (sec_fire && op_reg == OP_PROT) begin
			sector_next = sector_reg | sec_onehot;
		end else if (sec_fire) begin
			sector_next = sector_reg & ~sec_onehot;
		end
	end

	// Latch: set, cleared, or spent by any write-type command ending
	always_comb begin
		wel_next = wel_reg;
		if (exec_ok && op_reg == OP_WREN) begin
			wel_next = 1'b1;
		end else if (exec_ok && op_reg == OP_WRDI) begin
			wel_next = 1'b0;
		end else if (cs_end && (op_reg == OP_WRSR || is_sector_cmd(op_reg))) begin
			// Aborted tries still spend the latch
			wel_next = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link shifting

	// Edge history and sequencer state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sck_d_reg <= 1'b0;
			cs_n_d_reg <= 1'b1;
			state_reg <= ST_IDLE;
		end else begin
			sck_d_reg <= sck_s;
			cs_n_d_reg <= cs_n_s;
			state_reg <= state_next;
		end
	end

	// Bit counter restarts on each selection
	always_ff @(posedge clk_i) begin
		if (reset_i || cs_n_s) begin
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end else if (sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg <= shift_in;
		end
	end

	// Opcode is kept past release so execution can see it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			op_reg <= 8'h00;
		end else if (state_reg == ST_OPCODE && byte_done) begin
			op_reg <= shift_in;
		end else if (state_reg == ST_IDLE) begin
			op_reg <= 8'h00;
		end
	end

	// Address capture: sector index sits in the first address byte
	always_ff @(posedge clk_i) begin
		if (reset_i || state_reg == ST_IDLE) begin
			addr_cnt_reg <= 2'h0;
			addr_done_reg <= 1'b0;
			sec_sel_reg <= '0;
		end else if (state_reg == ST_ADDR && byte_done) begin
			addr_cnt_reg <= addr_cnt_reg + 2'h1;
			addr_done_reg <= last_addr;
			if (addr_cnt_reg == 2'h0) begin
				sec_sel_reg <= shift_in[SEC_W-1:0];
			end
		end
	end

	// Status write data byte; only the first one counts
	always_ff @(posedge clk_i) begin
		if (reset_i || state_reg == ST_IDLE) begin
			data_reg <= 8'h00;
			got_data_reg <= 1'b0;
		end else if (state_reg == ST_DATA && byte_done) begin
			data_reg <= shift_in;
			got_data_reg <= 1'b1;
		end
	end

	// Output byte: loaded as the output phase opens, then rotated
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			out_shift_reg <= 8'h00;
		end else if (state_reg != ST_OUT && state_next == ST_OUT) begin
			out_shift_reg <= (op_reg == OP_RDSP) ? rdsp_byte : status_byte;
		end else if (state_reg == ST_OUT && sck_fall) begin
			// Rotation makes the byte repeat with no reload
			out_shift_reg <= {out_shift_reg[6:0], out_shift_reg[7]};
		end
	end

	// Pin driver: change on falling edges, float on release
	always_ff @(posedge clk_i) begin
		if (reset_i || cs_n_s) begin
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
		end else if (state_reg == ST_OUT && sck_fall) begin
			so_reg <= out_shift_reg[7];
			so_oe_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protection state

	// Every sector protected out of reset
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sector_reg <= SECTOR_RST;
			lock_reg <= LOCK_RST;
			wel_reg <= WEL_RST;
		end else begin
			sector_reg <= sector_next;
			lock_reg <= lock_next;
			wel_reg <= wel_next;
		end
	end

	// Summary and lock view; one cycle behind the bits they describe
	wire [1:0] summary_next = (&sector_reg) ? SUM_ALL :
		((|sector_reg) ? SUM_SOME : SUM_NONE);
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			summary_reg <= SUM_ALL;
			hard_lock_reg <= 1'b0;
		end else begin
			summary_reg <= summary_next;
			hard_lock_reg <= ~wp_n_s & lock_reg;
		end
	end

	// Status byte is registered so the port comes from a flop
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			status_o <= 8'h00;
		end else begin
			status_o <= status_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign spi_so_o = so_reg;
	assign spi_so_oe_o = so_oe_reg;
	assign sector_protect_o = sector_reg;
	assign protection_lock_bit_o = lock_reg;
	assign write_enable_latch_o = wel_reg;
	assign software_protect_summary_o = summary_reg;
	assign hard_locked_o = hard_lock_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks

	glob_protect_a: assert property (@(posedge clk_i) disable iff (reset_i)
		wsr_fire && !lock_reg && data_reg[5:2] == 4'hF |=> &sector_reg)
		else $error("global protect missed");

	glob_unprotect_a: assert property (@(posedge clk_i) disable iff (reset_i)
		wsr_fire && !lock_reg && data_reg[5:2] == 4'h0 |=> sector_reg == '0)
		else $error("global unprotect missed");

	mixed_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
		wsr_fire && data_reg[5:2] != 4'hF && data_reg[5:2] != 4'h0
		|=> $stable(sector_reg))
		else $error("mixed pattern changed sectors");

	lock_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
		wsr_fire && !lock_reg |=> lock_reg == $past(data_reg[7]))
		else $error("lock bit not loaded");

	hard_lock_a: assert property (@(posedge clk_i) disable iff (reset_i)
		wsr_fire && lock_reg && !wp_n_s |=> lock_reg && $stable(sector_reg))
		else $error("write leaked through hard lock");

	soft_lock_a: assert property (@(posedge clk_i) disable iff (reset_i)
		wsr_fire && lock_reg && wp_n_s && !data_reg[7]
		|=> !lock_reg && $stable(sector_reg))
		else $error("soft lock release wrong");

	latch_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
		cs_end && op_reg == OP_WRSR && !wel_reg
		|=> $stable(lock_reg) && $stable(sector_reg) && !wel_reg)
		else $error("status write without latch");

	release_float_a: assert property (@(posedge clk_i) disable iff (reset_i)
		cs_n_s |=> !so_oe_reg ##1 !so_oe_reg)
		else $error("output driven after release");

	read_value_a: assert property (@(posedge clk_i) disable iff (reset_i)
		so_oe_reg && state_reg == ST_OUT && op_reg == OP_RDSP |-> so_reg == sec_bit)
		else $error("protection read value wrong");

	summary_a: assert property (@(posedge clk_i) disable iff (reset_i)
		sector_reg == '0 ##1 sector_reg == '0 |-> summary_reg == SUM_NONE)
		else $error("summary wrong for none");

endmodule : fsp_ctrl

/* fsp_spi_host.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Mode 0 host: clock idles low and runs only inside a frame
module fsp_spi_host (
	// Clock
	input wire logic clk_i,
	// Serial link, host side
	input wire logic so_i,
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	// Reply bits and frame end strobe
	output logic [7:0] rx_o,
	output logic done_o
);
	// Idle levels at time zero
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		rx_o = 8'h00;
		done_o = 1'b0;
	end

	// One frame, nbits from the low end of bits, MSB first; reply after skip bits
	task automatic frame(input logic [47:0] bits, input int nbits, input int skip);
		cs_n_o <= 1'b0;
		rx_o <= 8'h00;
		repeat (4) @(posedge clk_i);
		for (int i = nbits - 1; i >= 0; i--) begin
			si_o <= bits[i];
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			// Sampled late in the high phase: the reply lags the falling edge
			if (nbits - 1 - i >= skip) begin
				rx_o <= {rx_o[6:0], so_i};
			end
			sck_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// Released data line must not keep its last level
		si_o <= ~si_o;
		repeat (8) @(posedge clk_i);
		done_o <= 1'b1;
		@(posedge clk_i);
		done_o <= 1'b0;
	endtask : frame
endmodule : fsp_spi_host

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin mismatches++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
////////////////////////////////////////////////////////////////////////////////
module testbench;
	import fsp_pkg::*;
	// Expected state after one frame
	typedef struct packed {
		logic [7:0] rx;
		logic [NUM_SECTORS-1:0] sec;
		logic lock;
		logic write_enable_latch;
		logic wp;
	} fsp_note_type;
	logic clk_i;
	logic reset_i;
	logic wp_n_i;
	wire logic sck;
	wire logic cs_n;
	wire logic si;
	logic so;
	logic so_oe;
	logic so_last;
	wire logic so_line;
	logic [NUM_SECTORS-1:0] sector_protect;
	logic lock;
	logic write_enable_latch;
	logic [1:0] summary;
	logic hard;
	logic [7:0] status;
	logic [7:0] host_rx;
	logic done;
	int mismatches;
	int checks;
	fsp_note_type notes[$];
	fsp_note_type cur;
	// Reference state, worked from the rules
	logic [NUM_SECTORS-1:0] m_sec;
	logic m_lock;
	logic m_wel;

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	fsp_ctrl i_dut (.clk_i(clk_i), .reset_i(reset_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
		.spi_si_i(si), .spi_so_o(so), .spi_so_oe_o(so_oe), .wp_n_i(wp_n_i),
		.sector_protect_o(sector_protect), .protection_lock_bit_o(lock),
		.write_enable_latch_o(write_enable_latch), .software_protect_summary_o(summary),
		.hard_locked_o(hard), .status_o(status));
	fsp_spi_host i_host (.clk_i(clk_i), .so_i(so_line), .sck_o(sck), .cs_n_o(cs_n),
		.si_o(si), .rx_o(host_rx), .done_o(done));

	// Floating reply line shows the inverse of its last driven bit
	always @(posedge clk_i) begin
		if (reset_i) begin
			so_last <= 1'b0;
		end else if (so_oe) begin
			so_last <= so;
		end
	end
	assign so_line = so_oe ? so : ~so_last;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [1:0] sum_of(input logic [NUM_SECTORS-1:0] s);
		return (s == 4'hF) ? SUM_ALL : ((s == 4'h0) ? SUM_NONE : SUM_SOME);
	endfunction : sum_of

	task automatic note(input logic [7:0] rx);
		notes.push_back('{rx, m_sec, m_lock, m_wel, wp_n_i});
	endtask : note

	task automatic set_wp(input logic v);
		wp_n_i <= v;
		repeat (4) @(posedge clk_i);
	endtask : set_wp

	task automatic wren();
		m_wel = 1'b1;
		note(8'h00);
		i_host.frame({40'h00_0000_0000, OP_WREN}, 8, 32);
	endtask : wren

	// Latch cleared by its own command
	task automatic wrdi();
		m_wel = 1'b0;
		note(8'h00);
		i_host.frame({40'h00_0000_0000, OP_WRDI}, 8, 32);
	endtask : wrdi

	// Status read: reply starts after the opcode byte
	task automatic rdsr();
		note({m_lock, 2'b00, wp_n_i, sum_of(m_sec), m_wel, 1'b0});
		i_host.frame({32'h0000_0000, OP_RDSR, 8'h00}, 16, 8);
	endtask : rdsr

	// Status write: hard lock refuses, soft lock loads only the lock bit
	task automatic wrsr(input logic [7:0] d);
		if (m_wel && !(!wp_n_i && m_lock)) begin
			if (!m_lock && d[GLOB_HI:GLOB_LO] == 4'hF) m_sec = 4'hF;
			if (!m_lock && d[GLOB_HI:GLOB_LO] == 4'h0) m_sec = 4'h0;
			m_lock = d[ST_LOCK];
		end
		m_wel = 1'b0;
		note(8'h00);
		i_host.frame({32'h0000_0000, OP_WRSR, d}, 16, 32);
	endtask : wrsr

	task automatic sec_cmd(input logic [7:0] op, input logic [1:0] s);
		if (m_wel && !m_lock) m_sec[s] = (op == OP_PROT);
		m_wel = 1'b0;
		note(8'h00);
		i_host.frame({16'h0000, op, 6'h00, s, 16'($urandom)}, 32, 32);
	endtask : sec_cmd

	// Protection read with n reply bits, n from 1 to 8
	task automatic rdsp(input logic [1:0] s, input int n);
		logic [7:0] ex;
		ex = {8{m_sec[s]}};
		if (n < 8) ex = ex & ((8'h01 << n) - 8'h01);
		note(ex);
		i_host.frame({8'h00, OP_RDSP, 6'h00, s, 16'($urandom), 8'h00} >> (8 - n), 32 + n, 32);
	endtask : rdsp

	task automatic complete_run();
		if (notes.size() != 0) mismatches++;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////////
	// Oldest note against the outputs at each frame end
	always @(posedge clk_i) begin
		// A frame end with no note behind it is a bench fault
		if (done === 1'b1 && notes.size() == 0) begin
			mismatches++;
			$display("[FAIL] notes expected entry seen empty");
		end
		if (done === 1'b1 && notes.size() != 0) begin
			cur = notes.pop_front();
			`CHK("reply", cur.rx, host_rx)
			`CHK("sectors", cur.sec, sector_protect)
			`CHK("lock", cur.lock, lock)
			`CHK("latch", cur.write_enable_latch, write_enable_latch)
			`CHK("summary", sum_of(cur.sec), summary)
			`CHK("hard lock", !cur.wp && cur.lock, hard)
			`CHK("status", {cur.lock, 2'b00, cur.wp, sum_of(cur.sec), cur.write_enable_latch, 1'b0}, status)
			`CHK("so enable", 1'b0, so_oe)
		end
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_i);
		mismatches++;
		$display("[FAIL] run length expected finish seen timeout");
		complete_run();
	end

	// Main sequence
	initial begin
		logic [7:0] d;
		reset_i = 1'b1;
		wp_n_i = 1'b1;
		m_sec = SECTOR_RST;
		m_lock = LOCK_RST;
		m_wel = WEL_RST;
		mismatches = 0;
		checks = 0;
		void'($urandom(32'h0000_365b));
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rdsp(2'd3, 8);
		wrsr(8'h00);
		wren();
		rdsr();
		wrdi();
		wrsr(8'h7F);
		wren();
		wrsr(8'h00);
		wren();
		sec_cmd(OP_PROT, 2'd2);
		rdsp(2'd2, 8);
		rdsp(2'd1, 8);
		set_wp(1'b0);
		rdsp(2'd2, 5);
		set_wp(1'b1);
		wren();
		wrsr(8'hF0);
		wren();
		sec_cmd(OP_UNPROT, 2'd2);
		wren();
		wrsr(8'h7F);
		wren();
		wrsr(8'h7F);
		wren();
		sec_cmd(OP_UNPROT, 2'd0);
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			wren();
			wrsr({1'b0, d[6:0]});
		end
		wren();
		wrsr(8'hFF);
		set_wp(1'b0);
		wren();
		wrsr(8'h00);
		set_wp(1'b1);
		wren();
		wrsr(8'h0F);
		wren();
		sec_cmd(OP_UNPROT, 2'd1);
		// Status write cut off mid-byte: aborted, latch still spent
		wren();
		m_wel = 1'b0;
		note(8'h00);
		i_host.frame({36'h0_0000_0000, OP_WRSR, 4'h0}, 12, 32);
		// Reset in mid-run brings every sector back to protected
		reset_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		m_sec = SECTOR_RST;
		m_lock = LOCK_RST;
		m_wel = WEL_RST;
		repeat (4) @(posedge clk_i);
		rdsp(2'd1, 8);
		repeat (2) @(posedge clk_i);
		complete_run();
	end
endmodule : testbench
